// File: logic/dcf_defs.vh
// constants for the dual-clock fifo with programmable flags
// assumes inclusion by the fifo design file only
`ifndef DCF_DEFS_VH
`define DCF_DEFS_VH
`define DCF_WIDTH          9
`define DCF_ADDR_BITS      16
`define DCF_DEPTH          17'h1_0000
`define DCF_OFFSET_DEFAULT 9'h007
`define DCF_OFFSET_ZERO    9'h000
`define DCF_SEL_EMPTY_LOW  2'h0
`define DCF_SEL_EMPTY_HIGH 2'h1
`define DCF_SEL_FULL_LOW   2'h2
`define DCF_SEL_FULL_HIGH  2'h3
`define DCF_STAGE_DEPTH    4'h8
`endif

// File: logic/dcf_fifo.v
// dual-clock 9-bit fifo with programmable almost flags, offset registers and replay
// assumes wclk and rclk free running; inputs synchronous to their own clock; reset_n
// is sampled on both clocks and held low for at least two edges of each
// Function
// - default almost thresholds seven from empty/full
// - empty flags on read clock, full on write
// - reset gives empty, outputs low
// - load pin at reset selects standalone mode
// - write stores word when enabled, not full
// - read presents next word when not empty
// - output enable low drives data, else off
// - cascaded, only read-enabled device drives data
// - full holds up to eight writes in staging, empty blocks reads
// - empty fifo keeps last read word
// - load writes four offset registers cyclically
// - offset sequence position persists across load
// - load reads offset registers in same order
// - load high writes fifo; enable high no-op
// - almost-empty registered, low at n or fewer
// - almost-full registered, low at depth minus m
// - full at depth, empty at zero words
// - replay pulse rewinds read pointer, standalone only
// - replay re-reads data up to write pointer
`timescale 1ns/10ps
`include "dcf_defs.vh"

// small staging fifo between the write pins and the main array
module dcf_stage #(
    parameter WIDTH = 9,
    parameter DEPTH = 8,
    parameter AW    = 3
) (
    input  wire             clk,       // write clock
    input  wire             reset,     // synchronous, active high
    input  wire [WIDTH-1:0] in_data,   // word offered
    input  wire             in_valid,  // word offered this cycle
    output wire             in_ready,  // room available
    output wire [WIDTH-1:0] out_data,  // head word
    output wire             out_valid, // head valid
    input  wire             out_ready  // drain accepts head
);
    reg [WIDTH-1:0] mem [0:DEPTH-1];
    reg [AW:0]      wr_ptr;
    reg [AW:0]      rd_ptr;
    wire            push;
    wire            pop;
    wire [AW:0]     used;      // words held; top bit set means full
    integer         i;

    // depth is a power of two, so a full stage shows as the top count bit
    assign used      = wr_ptr - rd_ptr;
    assign in_ready  = !used[AW] && !reset;
    assign out_valid = wr_ptr != rd_ptr;
    assign out_data  = mem[rd_ptr[AW-1:0]];
    assign push      = in_valid && in_ready;
    assign pop       = out_valid && out_ready;

    // pointer and storage update
    always @(posedge clk) begin
        if (reset) begin
            wr_ptr <= {(AW+1){1'b0}};
            rd_ptr <= {(AW+1){1'b0}};
            for (i = 0; i < DEPTH; i = i + 1) begin
                mem[i] <= {WIDTH{1'b0}};
            end
        end else begin
            if (push) begin
                mem[wr_ptr[AW-1:0]] <= in_data;
                wr_ptr              <= wr_ptr + 1'b1;
            end
            if (pop) begin
                rd_ptr <= rd_ptr + 1'b1;
            end
        end
    end
endmodule

module dcf_fifo (
    input  wire                  wclk,           // write clock
    input  wire                  rclk,           // read clock
    input  wire                  reset_n,        // active-low reset, sampled per clock
    input  wire [`DCF_WIDTH-1:0] write_data,     // write data word
    input  wire                  write_en_n,     // active-low write enable
    input  wire                  read_en_n,      // active-low read enable
    input  wire                  output_en_n,    // active-low output enable
    input  wire                  offset_load_n,  // load pin, config strap at reset
    input  wire                  replay_pulse,   // retransmit, active high
    output reg  [`DCF_WIDTH-1:0] read_data_o,    // read data, driven value
    output wire [`DCF_WIDTH-1:0] read_data_oe,   // read data output enables
    output reg                   empty_flag_n,   // low when empty
    output reg                   full_flag_n,    // low when full
    output reg                   almost_empty_n, // low at n or fewer words
    output reg                   almost_full_n,  // low at depth-m or more words
    output wire                  write_ready     // staging fifo can take a word
);
    localparam AB = `DCF_ADDR_BITS;

    reg  [`DCF_WIDTH-1:0] mem [0:(1<<AB)-1];
    reg  [AB:0]           wr_ptr;          // write domain
    reg  [AB:0]           rd_ptr;          // read domain
    reg  [AB:0]           wr_gray;         // gray copy of write pointer
    reg  [AB:0]           rd_gray;         // gray copy of read pointer
    reg  [AB:0]           wr_ptr_rs1;      // gray write pointer into read domain
    reg  [AB:0]           wr_ptr_rs2;
    reg  [AB:0]           rd_ptr_ws1;      // gray read pointer into write domain
    reg  [AB:0]           rd_ptr_ws2;
    wire [AB:0]           wr_sync_bin;     // synchronised write pointer, binary
    wire [AB:0]           rd_sync_bin;     // synchronised read pointer, binary
    reg                   wr_rst_s;        // reset seen on write clock
    reg                   rd_rst_s;        // reset seen on read clock
    reg                   prog_mode;       // standalone mode chosen at reset
    reg  [8:0]            empty_offset_low;
    reg  [8:0]            empty_offset_high;
    reg  [8:0]            full_offset_low;
    reg  [8:0]            full_offset_high;
    reg  [1:0]            wr_sel;          // offset write sequence position
    reg  [1:0]            rd_sel;          // offset read sequence position
    reg                   read_owner;      // set in standalone and by reset, else read enabled last cycle
    wire [`DCF_WIDTH-1:0] stage_data;
    wire                  stage_valid;
    wire                  stage_ready;
    wire                  stage_in_valid;
    wire                  do_write;
    wire                  do_read;
    wire                  prog_write;
    wire                  prog_read;
    wire [AB:0]           next_wr_ptr;
    wire [AB:0]           next_rd_ptr;
    wire [AB:0]           next_wr_count;
    wire [AB:0]           next_rd_count;
    wire [AB:0]           n_value;
    wire [AB:0]           m_value;

    // reset stage per clock holds off transfers; pointers and flags clear on reset_n itself
    always @(posedge wclk) begin
        wr_rst_s <= !reset_n;
    end
    always @(posedge rclk) begin
        rd_rst_s <= !reset_n;
    end

    // pins gate the staging fifo: a word is offered only for a normal write
    assign prog_write     = prog_mode && !offset_load_n && !write_en_n;
    assign stage_in_valid = (offset_load_n || !prog_mode) && !write_en_n;
    assign write_ready    = stage_ready;

    dcf_stage #(
        .WIDTH (`DCF_WIDTH),
        .DEPTH (`DCF_STAGE_DEPTH),
        .AW    (3)
    ) u_stage (
        .clk       (wclk),
        .reset     (wr_rst_s || !reset_n),
        .in_data   (write_data),
        .in_valid  (stage_in_valid),
        .in_ready  (stage_ready),
        .out_data  (stage_data),
        .out_valid (stage_valid),
        .out_ready (full_flag_n && !wr_rst_s)
    );

    // write side counts with the synchronised read pointer
    assign n_value       = {empty_offset_high[7:0], empty_offset_low};
    assign m_value       = {full_offset_high[7:0], full_offset_low};
    assign do_write      = stage_valid && full_flag_n && !wr_rst_s;
    assign next_wr_ptr   = do_write ? wr_ptr + 1'b1 : wr_ptr;
    assign next_wr_count = next_wr_ptr - rd_sync_bin;

    // gray to binary per bit for both synchronised pointers
    genvar g;
    generate
        for (g = 0; g <= AB; g = g + 1) begin : g_gray
            assign wr_sync_bin[g] = ^wr_ptr_rs2[AB:g];
            assign rd_sync_bin[g] = ^rd_ptr_ws2[AB:g];
        end
    endgenerate

    // write clock: array, pointer, full flags, offset registers, strap
    always @(posedge wclk) begin
        rd_ptr_ws1 <= rd_gray;
        rd_ptr_ws2 <= rd_ptr_ws1;
        if (!reset_n) begin
            wr_ptr            <= {(AB+1){1'b0}};
            wr_gray           <= {(AB+1){1'b0}};
            full_flag_n       <= 1'b1;
            almost_full_n     <= 1'b1;
            empty_offset_low  <= `DCF_OFFSET_DEFAULT;
            empty_offset_high <= `DCF_OFFSET_ZERO;
            full_offset_low   <= `DCF_OFFSET_DEFAULT;
            full_offset_high  <= `DCF_OFFSET_ZERO;
            wr_sel            <= `DCF_SEL_EMPTY_LOW;
            prog_mode         <= !offset_load_n;
        end else begin
            if (do_write) begin
                mem[wr_ptr[AB-1:0]] <= stage_data;
            end
            wr_ptr        <= next_wr_ptr;
            wr_gray       <= next_wr_ptr ^ (next_wr_ptr >> 1);
            full_flag_n   <= next_wr_count != `DCF_DEPTH;
            almost_full_n <= next_wr_count < (`DCF_DEPTH - m_value);
            if (prog_write) begin
                case (wr_sel)
                    `DCF_SEL_EMPTY_LOW:  empty_offset_low  <= write_data;
                    `DCF_SEL_EMPTY_HIGH: empty_offset_high <= write_data;
                    `DCF_SEL_FULL_LOW:   full_offset_low   <= write_data;
                    default:             full_offset_high  <= write_data;
                endcase
                wr_sel <= wr_sel + 1'b1;
            end
        end
    end

    // read side counts with the synchronised write pointer
    assign prog_read     = prog_mode && !offset_load_n && !read_en_n;
    assign do_read       = !prog_read && !read_en_n && empty_flag_n && !rd_rst_s;
    assign next_rd_ptr   = (replay_pulse && prog_mode) ? {(AB+1){1'b0}}
                         : do_read ? rd_ptr + 1'b1 : rd_ptr;
    assign next_rd_count = wr_sync_bin - next_rd_ptr;

    // read clock: pointer, data register, empty flags, offset readback
    always @(posedge rclk) begin
        wr_ptr_rs1 <= wr_gray;
        wr_ptr_rs2 <= wr_ptr_rs1;
        if (!reset_n) begin
            rd_ptr         <= {(AB+1){1'b0}};
            rd_gray        <= {(AB+1){1'b0}};
            read_data_o    <= {`DCF_WIDTH{1'b0}};
            empty_flag_n   <= 1'b0;
            almost_empty_n <= 1'b0;
            rd_sel         <= `DCF_SEL_EMPTY_LOW;
            read_owner     <= 1'b1;
        end else begin
            rd_ptr  <= next_rd_ptr;
            rd_gray <= next_rd_ptr ^ (next_rd_ptr >> 1);
            if (do_read) begin
                read_data_o <= mem[rd_ptr[AB-1:0]];
            end else if (prog_read) begin
                case (rd_sel)
                    `DCF_SEL_EMPTY_LOW:  read_data_o <= empty_offset_low;
                    `DCF_SEL_EMPTY_HIGH: read_data_o <= empty_offset_high;
                    `DCF_SEL_FULL_LOW:   read_data_o <= full_offset_low;
                    default:             read_data_o <= full_offset_high;
                endcase
                rd_sel <= rd_sel + 1'b1;
            end
            empty_flag_n   <= next_rd_count != {(AB+1){1'b0}};
            almost_empty_n <= next_rd_count > n_value;
            read_owner     <= prog_mode || !read_en_n;
        end
    end

    // three-state control per data bit
    genvar b;
    generate
        for (b = 0; b < `DCF_WIDTH; b = b + 1) begin : g_oe
            assign read_data_oe[b] = !output_en_n && read_owner;
        end
    endgenerate
endmodule

// File: bench/dcf_fifo_sva.sv
// checker on dcf_fifo ports, bound below
// assumes reset_n low over several edges of each clock
`timescale 1ns/10ps
module dcf_fifo_sva (
    input wire       wclk,           // write clock
    input wire       rclk,           // read clock
    input wire       reset_n,        // reset
    input wire       read_en_n,      // read enable
    input wire       output_en_n,    // output enable
    input wire       offset_load_n,  // load and strap
    input wire [8:0] read_data_o,    // read data
    input wire [8:0] read_data_oe,   // drive enables
    input wire       empty_flag_n,   // empty
    input wire       full_flag_n,    // full
    input wire       almost_empty_n, // almost empty
    input wire       almost_full_n   // almost full
);
    // strap level seen during reset
    reg cascade;
    always @(posedge wclk) begin
        if (!reset_n)
            cascade <= offset_load_n;
    end
    // normal-mode read against an empty fifo
    sequence s_empty_read;
        !empty_flag_n && !read_en_n && offset_load_n;
    endsequence
    a_oe_off: assert property (@(posedge rclk) disable iff (!reset_n)
        output_en_n |-> read_data_oe == 9'h000) else $error("driven while off");
    a_oe_drive: assert property (@(posedge rclk) disable iff (!reset_n)
        !output_en_n && !cascade |-> read_data_oe == 9'h1ff) else $error("not driven");
    a_empty_hold: assert property (@(posedge rclk) disable iff (!reset_n)
        s_empty_read |=> $stable(read_data_o)) else $error("empty read moved data");
    a_empty_ae: assert property (@(posedge rclk) disable iff (!reset_n)
        !empty_flag_n |-> !almost_empty_n) else $error("empty but not almost");
    a_full_af: assert property (@(posedge wclk) disable iff (!reset_n)
        !full_flag_n |-> !almost_full_n) else $error("full but not almost");
    a_reset_read: assert property (@(posedge rclk) disable iff (!reset_n)
        $rose(reset_n) |-> read_data_o == 9'h000 && !empty_flag_n) else $error("rd reset");
    a_reset_write: assert property (@(posedge wclk) disable iff (!reset_n)
        $rose(reset_n) |-> full_flag_n && almost_full_n) else $error("wr reset");
    a_empty_by_read: assert property (@(posedge rclk) disable iff (!reset_n)
        $fell(empty_flag_n) |-> !$past(read_en_n) || !$past(read_en_n, 2))
        else $error("empty without read");
endmodule
bind dcf_fifo dcf_fifo_sva dcf_fifo_sva_i (
    .wclk(wclk), .rclk(rclk), .reset_n(reset_n), .read_en_n(read_en_n),
    .output_en_n(output_en_n), .offset_load_n(offset_load_n),
    .read_data_o(read_data_o), .read_data_oe(read_data_oe),
    .empty_flag_n(empty_flag_n), .full_flag_n(full_flag_n),
    .almost_empty_n(almost_empty_n), .almost_full_n(almost_full_n)
);

// File: bench/dcf_far_end.sv
// writer and reader logic at the fifo's data ports
// assumes one clock on both fifo clocks; driven at falling edges
`timescale 1ns/10ps
module dcf_far_end (
    input  wire       clk,          // fifo clock
    input  wire       write_ready,  // stage has room
    input  wire       empty_flag_n, // low when empty
    input  wire [8:0] read_data_o,  // read data
    output reg  [8:0] write_data,   // write word
    output reg        write_en_n,   // write enable
    output reg        read_en_n     // read enable
);
    integer k;
    // no access until the bench releases reset
    initial begin
        write_en_n = 1'b1;
        read_en_n = 1'b1;
        write_data = 9'h000;
    end
    // one word per call, back-to-back calls stream
    task put(input [8:0] dw, output ok);
        begin
            for (k = 0; k < 50 && write_ready !== 1'b1; k = k + 1) begin
                write_en_n = 1'b1;
                @(negedge clk);
            end
            ok = (k < 50);
            write_data = dw;
            write_en_n = !ok;
            @(negedge clk);
        end
    endtask
    // write enable off, released data line toggles
    task idle;
        begin
            write_en_n = 1'b1;
            write_data = ~write_data;
        end
    endtask
    // one read; any skips the wait for a word
    task get(input any, output [8:0] dr);
        begin
            for (k = 0; k < 50 && !any && empty_flag_n !== 1'b1; k = k + 1)
                @(negedge clk);
            read_en_n = 1'b0;
            @(negedge clk);
            read_en_n = 1'b1;
            dr = (k < 50) ? read_data_o : 9'hxxx;
            @(negedge clk);
        end
    endtask
endmodule

// File: bench/dcf_fifo_bench.sv
// self-checking bench for dcf_fifo, both clocks from clk
// assumes the checker binds itself and dcf_far_end moves data
`timescale 1ns/10ps
module dcf_fifo_bench;
    reg        clk, reset_n, output_en_n, offset_load_n, replay_pulse, ok;
    reg  [8:0] d;
    integer    i, fails, n_compared;
    wire [8:0] write_data, read_data_o, read_data_oe;
    wire       write_en_n, read_en_n, empty_flag_n, full_flag_n;
    wire       almost_empty_n, almost_full_n, write_ready;
    // empty, almost empty, full, almost full
    wire [8:0] flg = {5'h00, empty_flag_n, almost_empty_n, full_flag_n, almost_full_n};
    dcf_fifo dcf_fifo_i (
        .wclk(clk), .rclk(clk), .reset_n(reset_n), .write_data(write_data),
        .write_en_n(write_en_n), .read_en_n(read_en_n), .output_en_n(output_en_n),
        .offset_load_n(offset_load_n), .replay_pulse(replay_pulse),
        .read_data_o(read_data_o), .read_data_oe(read_data_oe),
        .empty_flag_n(empty_flag_n), .full_flag_n(full_flag_n),
        .almost_empty_n(almost_empty_n), .almost_full_n(almost_full_n),
        .write_ready(write_ready));
    dcf_far_end dcf_far_end_i (
        .clk(clk), .write_ready(write_ready), .empty_flag_n(empty_flag_n),
        .read_data_o(read_data_o), .write_data(write_data),
        .write_en_n(write_en_n), .read_en_n(read_en_n));
    task check(input [8:0] got, input [8:0] exp);
        begin
            n_compared = n_compared + 1;
            if (got !== exp) begin
                fails = fails + 1;
                $display("unexpected at %0t: got %h want %h", $time, got, exp);
            end
        end
    endtask
    task finish_test;
        begin
            if (fails == 0 && n_compared > 0)
                $display("ALL TESTS PASSED");
            else
                $display("TESTS FAILED");
            $finish;
        end
    endtask
    // reset with standalone strap, then reset values
    task do_reset;
        begin
            reset_n = 1'b0;
            offset_load_n = 1'b0;
            repeat (6) @(negedge clk);
            reset_n = 1'b1;
            repeat (2) @(negedge clk);
            check(read_data_o, 9'h000);
            check(flg, 9'h003);
        end
    endtask
    task drain3;
        for (i = 0; i < 3; i = i + 1) begin
            dcf_far_end_i.get(1'b0, d);
            check(d, i == 0 ? 9'h1a5 : i == 1 ? 9'h05a : 9'h100);
        end
    endtask
    // offset defaults, then n=2 m=5 with a wrap and a load break
    task t_offsets;
        begin
            for (i = 0; i < 4; i = i + 1) begin
                dcf_far_end_i.get(1'b1, d);
                check(d, i[0] ? 9'h000 : 9'h007);
            end
            for (i = 0; i < 5; i = i + 1)
                dcf_far_end_i.put(i == 0 ? 9'h003 : i == 2 ? 9'h005 : {8'h00, i == 4} << 1, ok);
            dcf_far_end_i.idle;
            offset_load_n = 1'b1;
            @(negedge clk);
            offset_load_n = 1'b0;
            dcf_far_end_i.put(9'h000, ok);
            check({8'h00, ok}, 9'h001);
            dcf_far_end_i.idle;
            offset_load_n = 1'b1;
        end
    endtask
    // threshold at n, ordered reads, read on empty
    task t_stream;
        begin
            dcf_far_end_i.put(9'h1a5, ok);
            dcf_far_end_i.put(9'h05a, ok);
            dcf_far_end_i.idle;
            repeat (8) @(negedge clk);
            check(flg, 9'h00b);
            dcf_far_end_i.put(9'h100, ok);
            check({8'h00, ok}, 9'h001);
            dcf_far_end_i.idle;
            repeat (8) @(negedge clk);
            check(flg, 9'h00f);
            drain3;
            repeat (2) @(negedge clk);
            check(flg, 9'h003);
            dcf_far_end_i.get(1'b1, d);
            check(d, 9'h100);
        end
    endtask
    // replay with enables held off, then a later word
    task t_replay;
        begin
            replay_pulse = 1'b1;
            @(negedge clk);
            replay_pulse = 1'b0;
            repeat (4) @(negedge clk);
            drain3;
            dcf_far_end_i.put(9'h0ff, ok);
            check({8'h00, ok}, 9'h001);
            dcf_far_end_i.idle;
            dcf_far_end_i.get(1'b0, d);
            check(d, 9'h0ff);
            output_en_n = 1'b1;
            #1 check(read_data_oe, 9'h000);
            output_en_n = 1'b0;
            #1 check(read_data_oe, 9'h1ff);
            @(negedge clk);
        end
    endtask
    // fill until refused, full flags, first word back
    task t_fill;
        begin
            do_reset;
            offset_load_n = 1'b1;
            ok = 1'b1;
            for (i = 0; i < 70000 && ok; i = i + 1)
                dcf_far_end_i.put(i[8:0], ok);
            dcf_far_end_i.idle;
            check({8'h00, i > 65536}, 9'h001);
            check(flg, 9'h00c);
            dcf_far_end_i.get(1'b0, d);
            check(d, 9'h000);
            dcf_far_end_i.get(1'b0, d);
            check(d, 9'h001);
        end
    endtask
    // free-running clock
    initial begin
        clk = 1'b0;
        forever #5 clk = ~clk;
    end
    // main sequence
    initial begin
        reset_n = 1'b0;
        output_en_n = 1'b0;
        offset_load_n = 1'b0;
        replay_pulse = 1'b0;
        fails = 0;
        n_compared = 0;
        do_reset;
        t_offsets;
        t_stream;
        t_replay;
        t_fill;
        finish_test;
    end
endmodule
